// ### rtl/maab_alu_core.sv
// Combinational adder, AND unit and bit modifier
`default_nettype none
module maab_alu_core (
  // Operands in, result out
  maab_alu_if.core alu
);
  import maab_pkg::*;

  logic cin_eff;
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic [7:0] bit_mask;
  logic [7:0] res;

  always_comb begin
    // Plain add ignores the incoming carry
    cin_eff = (alu.op == OP_ADD_IMM_WITH_CARRY) ? alu.carry_in : 1'b0;
    low_sum = 5'(alu.opnd_a[3:0]) + 5'(alu.opnd_b[3:0]) + 5'(cin_eff);
    full_sum = 9'(alu.opnd_a) + 9'(alu.opnd_b) + 9'(cin_eff);
    bit_mask = BIT_ONE << alu.bit_sel;
    case (alu.op)
      OP_ADD_IMM_WITH_CARRY, OP_ADD_IMM: begin
        res = full_sum[7:0];
      end
      OP_AND_WORK_WITH_FILE, OP_AND_WORK_WITH_IMM: begin
        res = alu.opnd_a & alu.opnd_b;
      end
      OP_BIT_CLEAR_FILE: begin
        res = alu.opnd_b & ~bit_mask;
      end
      OP_BIT_SET_FILE: begin
        res = alu.opnd_b | bit_mask;
      end
      default: begin
        res = alu.opnd_a;
      end
    endcase
  end

  assign alu.result = res;
  assign alu.zero = (res == 8'h00);
  assign alu.nibble_carry = low_sum[4];
  assign alu.carry_out = full_sum[8];
endmodule
`default_nettype wire

// ### rtl/maab_alu_if.sv
// Operand and result bundle between the sequencer and the arithmetic core
`default_nettype none
interface maab_alu_if;
  import maab_pkg::*;
  maab_op_t op;
  logic [7:0] opnd_a;
  logic [7:0] opnd_b;
  logic carry_in;
  logic [2:0] bit_sel;
  logic [7:0] result;
  logic zero;
  logic nibble_carry;
  logic carry_out;

  modport ctrl (
    output op, opnd_a, opnd_b, carry_in, bit_sel,
    input result, zero, nibble_carry, carry_out
  );
  modport core (
    input op, opnd_a, opnd_b, carry_in, bit_sel,
    output result, zero, nibble_carry, carry_out
  );
endinterface
`default_nettype wire

// ### rtl/maab_exec.sv
// Single-cycle execution of add, AND and bit set/clear operations
`default_nettype none
module maab_exec #(
  parameter int unsigned ADDR_W = maab_pkg::FILE_ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Operation request
  input wire logic op_valid,
  input wire maab_pkg::maab_op_t op_code,
  input wire logic dest_to_file,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic [maab_pkg::BIT_IDX_W-1:0] bit_sel,
  input wire logic [7:0] imm_in,
  // File register read data for file_addr
  input wire logic [7:0] file_rd_data,
  // Working register and status flags
  output logic [7:0] working_register_ff,
  output logic zero_flag_ff,
  output logic nibble_carry_flag_ff,
  output logic carry_flag_ff,
  // File register write-back
  output logic file_wr_en_ff,
  output logic [ADDR_W-1:0] file_wr_addr_ff,
  output logic [7:0] file_wr_data_ff,
  // Completion
  output logic op_done_ff
);
  import maab_pkg::*;

  if (ADDR_W < 1 || ADDR_W > FILE_ADDR_W) begin : g_addr_chk
    $error("maab_exec: ADDR_W must be 1 to 7");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic op_legal;
  logic is_add;
  logic uses_file;
  logic to_work;
  logic to_file;
  logic upd_zero;

  always_comb begin
    op_legal = 1'b1;
    is_add = 1'b0;
    uses_file = 1'b0;
    to_work = 1'b0;
    to_file = 1'b0;
    upd_zero = 1'b0;
    case (op_code)
      OP_ADD_IMM_WITH_CARRY, OP_ADD_IMM: begin
        is_add = 1'b1;
        to_work = 1'b1;
        upd_zero = 1'b1;
      end
      OP_AND_WORK_WITH_FILE: begin
        uses_file = 1'b1;
        to_work = ~dest_to_file;
        to_file = dest_to_file;
        upd_zero = 1'b1;
      end
      OP_AND_WORK_WITH_IMM: begin
        to_work = 1'b1;
        upd_zero = 1'b1;
      end
      OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE: begin
        uses_file = 1'b1;
        to_file = 1'b1;
      end
      default: begin
        op_legal = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Arithmetic core
  // ----------------------------------------------------------------
  maab_alu_if alu_bus ();

  assign alu_bus.op = op_code;
  assign alu_bus.opnd_a = working_register_ff;
  assign alu_bus.opnd_b = uses_file ? file_rd_data : imm_in;
  assign alu_bus.carry_in = carry_flag_ff;
  assign alu_bus.bit_sel = bit_sel;

  maab_alu_core u_core (
    .alu(alu_bus.core)
  );

  logic take;
  assign take = op_valid && op_legal;

  // ----------------------------------------------------------------
  // Working register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      working_register_ff <= WORK_RST;
    end else if (take && to_work) begin
      working_register_ff <= alu_bus.result;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_flag_ff <= FLAG_RST;
    end else if (take && upd_zero) begin
      zero_flag_ff <= alu_bus.zero;
    end
  end

  // Only additions touch carry and nibble carry
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nibble_carry_flag_ff <= FLAG_RST;
      carry_flag_ff <= FLAG_RST;
    end else if (take && is_add) begin
      nibble_carry_flag_ff <= alu_bus.nibble_carry;
      carry_flag_ff <= alu_bus.carry_out;
    end
  end

  // ----------------------------------------------------------------
  // File write-back and completion
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      file_wr_en_ff <= 1'b0;
      file_wr_addr_ff <= '0;
      file_wr_data_ff <= 8'h00;
    end else begin
      file_wr_en_ff <= take && to_file;
      if (take && to_file) begin
        file_wr_addr_ff <= file_addr;
        file_wr_data_ff <= alu_bus.result;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_done_ff <= 1'b0;
    end else begin
      op_done_ff <= take;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [8:0] chk_adc;
  logic [8:0] chk_add;
  logic [4:0] chk_low;
  logic [7:0] chk_mask;
  logic [7:0] chk_and_file;
  logic [7:0] chk_and_imm;
  logic [7:0] chk_clr;
  logic [7:0] chk_set;
  assign chk_adc = 9'(working_register_ff) + 9'(imm_in) + 9'(carry_flag_ff);
  assign chk_add = 9'(working_register_ff) + 9'(imm_in);
  assign chk_low = 5'(working_register_ff[3:0]) + 5'(imm_in[3:0]);
  assign chk_mask = BIT_ONE << bit_sel;
  assign chk_and_file = working_register_ff & file_rd_data;
  assign chk_and_imm = working_register_ff & imm_in;
  assign chk_clr = file_rd_data & ~chk_mask;
  assign chk_set = file_rd_data | chk_mask;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence clr_issue;
    op_valid && op_code == OP_BIT_CLEAR_FILE;
  endsequence
  sequence set_issue;
    op_valid && op_code == OP_BIT_SET_FILE;
  endsequence
  sequence flags_held;
    $stable(zero_flag_ff) && $stable(nibble_carry_flag_ff) && $stable(carry_flag_ff);
  endsequence

  add_carry_sum_a: assert property (op_valid && op_code == OP_ADD_IMM_WITH_CARRY |=>
      working_register_ff == $past(chk_adc[7:0]) && op_done_ff)
    else $error("add with carry gave wrong sum");

  add_plain_sum_a: assert property (op_valid && op_code == OP_ADD_IMM |=>
      working_register_ff == $past(chk_add[7:0]) && carry_flag_ff == $past(chk_add[8]))
    else $error("plain add gave wrong sum or used carry");

  and_file_dest_a: assert property (op_valid && op_code == OP_AND_WORK_WITH_FILE |=>
      ($past(dest_to_file) ? (file_wr_en_ff && $stable(working_register_ff)
        && file_wr_addr_ff == $past(file_addr))
       : (!file_wr_en_ff && working_register_ff == $past(chk_and_file))))
    else $error("file AND went to wrong destination");

  and_file_flags_a: assert property (op_valid && op_code == OP_AND_WORK_WITH_FILE |=>
      $stable(carry_flag_ff) && $stable(nibble_carry_flag_ff)
      && zero_flag_ff == ($past(chk_and_file) == 8'h00))
    else $error("file AND changed wrong flags");

  and_imm_result_a: assert property (op_valid && op_code == OP_AND_WORK_WITH_IMM |=>
      working_register_ff == $past(chk_and_imm) && $stable(carry_flag_ff)
      && !file_wr_en_ff)
    else $error("immediate AND result wrong");

  bit_clear_a: assert property (clr_issue |=> flags_held ##0
      (file_wr_en_ff && file_wr_data_ff == $past(chk_clr)))
    else $error("bit clear wrong");

  bit_set_a: assert property (set_issue |=> flags_held ##0
      (file_wr_en_ff && file_wr_data_ff == $past(chk_set)))
    else $error("bit set wrong");

  carry_out_a: assert property (op_valid && op_code == OP_ADD_IMM_WITH_CARRY |=>
      carry_flag_ff == $past(chk_adc[8]))
    else $error("carry flag wrong after add");

  nibble_zero_a: assert property (op_valid && op_code == OP_ADD_IMM |=>
      nibble_carry_flag_ff == $past(chk_low[4]) && zero_flag_ff == (working_register_ff == 8'h00))
    else $error("zero or nibble carry wrong");

  idle_quiet_a: assert property (!op_valid |=> flags_held ##0 (!op_done_ff && !file_wr_en_ff
      && $stable(working_register_ff)))
    else $error("state changed without a request");
endmodule
`default_nettype wire

// ### rtl/maab_pkg.sv
// Shared constants and types for the add and bit-operation datapath
`default_nettype none
package maab_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILE_ADDR_W = 7;
  localparam int unsigned BIT_IDX_W = 3;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [7:0] BIT_ONE = 8'h01;

  typedef enum logic [2:0] {
    OP_ADD_IMM_WITH_CARRY = 3'b000,
    OP_ADD_IMM = 3'b001,
    OP_AND_WORK_WITH_FILE = 3'b010,
    OP_AND_WORK_WITH_IMM = 3'b011,
    OP_BIT_CLEAR_FILE = 3'b100,
    OP_BIT_SET_FILE = 3'b101
  } maab_op_t;
endpackage
`default_nettype wire

// ### tb/test_mcu_alu_add_and_bit_ops.sv
// Self-checking bench for the add, AND and bit-operation datapath
`default_nettype none
module test_mcu_alu_add_and_bit_ops;
  timeunit 1ns;
  timeprecision 1ps;
  import maab_pkg::*;

  // ----------------------------------------
  // Expected-result note
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] w;
    logic [2:0] f;
    logic we;
    logic [7:0] wd;
    logic [6:0] wa;
    int t;
  } maab_note_t;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  maab_op_t op_code = OP_ADD_IMM;
  logic dest_to_file = 1'b0;
  logic [6:0] file_addr = 7'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] imm_in = 8'h00;
  logic [7:0] file_rd_data = 8'h00;
  logic [7:0] working_register_ff;
  logic [7:0] file_wr_data_ff;
  logic [6:0] file_wr_addr_ff;
  logic zero_flag_ff, nibble_carry_flag_ff, carry_flag_ff, file_wr_en_ff, op_done_ff;
  logic [7:0] mem [128];
  logic [7:0] w_m = 8'h00;
  logic [2:0] f_m = 3'h0;
  maab_note_t notes[$];
  int bad_count = 0;
  int n_checks = 0;
  int seed = 87698;
  int cyc = 0;

  always #2 core_clk = ~core_clk;

  maab_exec #(.ADDR_W(7)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .dest_to_file(dest_to_file), .file_addr(file_addr), .bit_sel(bit_sel),
    .imm_in(imm_in), .file_rd_data(file_rd_data),
    .working_register_ff(working_register_ff), .zero_flag_ff(zero_flag_ff),
    .nibble_carry_flag_ff(nibble_carry_flag_ff), .carry_flag_ff(carry_flag_ff),
    .file_wr_en_ff(file_wr_en_ff), .file_wr_addr_ff(file_wr_addr_ff),
    .file_wr_data_ff(file_wr_data_ff), .op_done_ff(op_done_ff)
  );

  // ----------------------------------------
  // Compare, drive and finish
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (notes.size() != 0) bad_count++;
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_op(input maab_op_t op, input logic d, input logic [6:0] a,
                       input logic [2:0] b, input logic [7:0] i);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic cin;
    maab_note_t n;
    @(negedge core_clk);
    op_valid = 1'b1;
    op_code = op;
    dest_to_file = d;
    file_addr = a;
    bit_sel = b;
    imm_in = i;
    file_rd_data = mem[a];
    n = '{w: w_m, f: f_m, we: 1'b0, wd: 8'h00, wa: a, t: cyc + 1};
    r = mem[a];
    case (op)
      OP_ADD_IMM_WITH_CARRY, OP_ADD_IMM: begin
        cin = (op == OP_ADD_IMM_WITH_CARRY) ? f_m[0] : 1'b0;
        s = {1'b0, w_m} + {1'b0, i} + {8'h00, cin};
        h = {1'b0, w_m[3:0]} + {1'b0, i[3:0]} + {4'h0, cin};
        n.w = s[7:0];
        n.f = {s[7:0] == 8'h00, h[4], s[8]};
      end
      OP_AND_WORK_WITH_FILE, OP_AND_WORK_WITH_IMM: begin
        r = w_m & ((op == OP_AND_WORK_WITH_IMM) ? i : mem[a]);
        n.f[2] = (r == 8'h00);
        if (op == OP_AND_WORK_WITH_FILE && d) n.we = 1'b1;
        else n.w = r;
      end
      OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE: begin
        r[b] = (op == OP_BIT_SET_FILE);
        n.we = 1'b1;
      end
      default: return;
    endcase
    n.wd = r;
    notes.push_back(n);
    w_m = n.w;
    f_m = n.f;
    if (n.we) mem[a] = r;
  endtask

  task automatic idle();
    @(negedge core_clk);
    op_valid = 1'b0;
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    maab_note_t n;
    cyc++;
    #1;
    if (op_done_ff === 1'b1 && notes.size() == 0) begin
      chk("op_done", 1, 0);
    end else if (op_done_ff === 1'b1) begin
      n = notes.pop_front();
      chk("latency", cyc, n.t);
      chk("working", working_register_ff, n.w);
      chk("zero", zero_flag_ff, n.f[2]);
      chk("nibble", nibble_carry_flag_ff, n.f[1]);
      chk("carry", carry_flag_ff, n.f[0]);
      chk("wr_en", file_wr_en_ff, n.we);
      if (n.we) chk("wr_data", file_wr_data_ff, n.wd);
      if (n.we) chk("wr_addr", file_wr_addr_ff, n.wa);
    end else if (file_wr_en_ff === 1'b1) begin
      chk("wr_en", 1, 0);
    end
  end

  initial begin
    #20000;
    bad_count++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    maab_op_t op;
    logic [31:0] rv;
    for (int k = 0; k < 128; k++) mem[k] = 8'($random(seed));
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    do_op(OP_ADD_IMM, 1'b0, 7'h00, 3'h0, 8'h12);
    do_op(OP_ADD_IMM, 1'b0, 7'h00, 3'h0, 8'hEE);
    do_op(OP_ADD_IMM_WITH_CARRY, 1'b0, 7'h00, 3'h0, 8'h34);
    do_op(maab_op_t'(3'b110), 1'b0, 7'h01, 3'h0, 8'h00);
    do_op(maab_op_t'(3'b111), 1'b1, 7'h01, 3'h0, 8'h00);
    for (int b = 0; b < 8; b++) begin
      do_op(OP_BIT_SET_FILE, 1'b0, 7'h7F, 3'(b), 8'h00);
      do_op(OP_BIT_CLEAR_FILE, 1'b1, 7'h7F, 3'(7 - b), 8'h00);
      do_op(OP_AND_WORK_WITH_FILE, b[0], 7'h7F, 3'h0, 8'h00);
    end
    for (int k = 0; k < 600; k++) begin
      rv = $random(seed);
      op = maab_op_t'(rv[2:0]);
      do_op(op, rv[3], rv[10:4], rv[13:11], rv[21:14]);
      if (rv[31]) idle();
      if (k == 300) begin
        idle();
        idle();
        arst_n = 1'b0;
        w_m = 8'h00;
        f_m = 3'h0;
        idle();
        arst_n = 1'b1;
      end
    end
    idle();
    idle();
    idle();
    conclude();
  end
endmodule
`default_nettype wire
